// [rtl/qrs_pkg.sv]
/*
 Constants shared by the quad serial read/sleep device and its host end.
 Assumes both ends are clocked by ref_clk_i at 250 MHz.
*/
package qrs_pkg;
	localparam logic [7:0] QRS_OP_QUAD_READ = 8'heb;
	localparam logic [7:0] QRS_OP_DUAL_READ = 8'hbb;
	localparam logic [7:0] QRS_OP_WRAP_SET = 8'h77;
	localparam logic [7:0] QRS_OP_MODE_RESET = 8'hff;
	localparam logic [7:0] QRS_OP_SLEEP = 8'hb9;
	localparam logic [7:0] QRS_OP_WAKE = 8'hab;
	localparam logic [1:0] QRS_SKIP_CODE = 2'h2;
	localparam int QRS_SKIP_LSB = 4;
	localparam int QRS_WRAP_DIS_BIT = 4;
	localparam int QRS_WRAP_LEN_LSB = 5;
	localparam int QRS_QE_BIT = 1;
	localparam logic [2:0] QRS_WRAP_RESET = 3'h1;
	localparam logic [3:0] QRS_LAT_RESET = 4'h6;
	localparam logic [7:0] QRS_SR2_RESET = 8'h02;
	localparam int QRS_ADDR_NIB = 6;
	localparam int QRS_SLEEP_NS = 3000;
	localparam int QRS_CLK_NS = 4;
	localparam int QRS_SLEEP_CYC = QRS_SLEEP_NS / QRS_CLK_NS;
	localparam int QRS_SCK_DIV = 8;
endpackage

// [rtl/qrs_if.sv]
/*
 Link between the host end and the device end: chip select, serial clock,
 four two-way data lines. Assumes the bench resolves lines from enables.
*/
`timescale 1ns/1ps
interface qrs_if;
	logic cs_n;
	logic sck;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe_n;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe_n;
	logic [3:0] io;
	modport host (output cs_n, output sck, output h_io_o, output h_io_oe_n,
		input io);
	modport dev (input cs_n, input sck, output d_io_o, output d_io_oe_n,
		input io);
endinterface

// [rtl/qrs_dev.sv]
/*
 Device end: command interpreter for quad I/O read with continuous mode,
 wrap setting, mode reset and deep sleep. Assumes a qrs_if link whose
 pins are sampled by ref_clk_i; data values come from a simple counter.
*/
//
// Notes on behaviour
// - Mode byte follows address; upper nibble decides
// - Lower mode nibble ignored, host may float
// - Host releases IO before first data edge
// - Mode 10 lets next read skip opcode
// - Other mode values restore full opcode
// - Variable latency from status reg three
// - Legacy quad read: six latency cycles
// - Wrap set: 77h, 24 dummy, wrap byte
// - Wrap bits 6..4 stored in register three
// - Bit 4 low enables wrap, 6..5 length
// - Wrapped read loops within aligned section
// - Wrap setting persists until changed
// - Wrap disabled after power-on
// - Quad read and wrap need quad enable
// - Mode bits updated by dual/quad reads
// - Reserved mode bits take any value
// - FFh/FFFFh resets continuous read mode
// - Host sends mode reset, then wrap off
// - Sleep only if select rises after byte
// - Sleep entered within entry time
// - In sleep only wake is decoded
// - Starts awake after power-up
// - Wake command is ABh
`timescale 1ns/1ps
module qrs_dev
	import qrs_pkg::*;
#(
	parameter int SLEEP_CYC = qrs_pkg::QRS_SLEEP_CYC,
	parameter logic VAR_LAT = 1'b0
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link
	qrs_if.dev lnk,
	// User side
	input wire logic [3:0] lat_cfg_i,
	input wire logic quad_en_i,
	output logic sleep_o,
	output logic [2:0] wrap_set_o,
	output logic skip_op_o,
	output logic [23:0] addr_o
);
	import qrs_pkg::*;

	typedef enum {ST_OP, ST_ADDR, ST_MODE, ST_LAT, ST_DATA, ST_WDUM,
		ST_WBYTE, ST_END, ST_IGN} qrs_dst_t;

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic cs_n_s1_ff, cs_n_ff, sck_s1_ff, sck_ff, sck_d_ff;
	logic [3:0] io_s1_ff, io_ff;
	always_ff @(posedge ref_clk_i) begin
		cs_n_s1_ff <= lnk.cs_n;
		cs_n_ff <= cs_n_s1_ff;
		sck_s1_ff <= lnk.sck;
		sck_ff <= sck_s1_ff;
		sck_d_ff <= sck_ff;
		io_s1_ff <= lnk.io;
		io_ff <= io_s1_ff;
	end
	wire sck_rise = sck_ff & ~sck_d_ff & ~cs_n_ff;
	wire sck_fall = ~sck_ff & sck_d_ff & ~cs_n_ff;
	logic cs_d_ff;
	always_ff @(posedge ref_clk_i) cs_d_ff <= cs_n_ff;
	wire cs_rise = cs_n_ff & ~cs_d_ff;

	////////////////////////////////////////////////////////////////
	// State
	qrs_dst_t st_ff;
	logic [7:0] sh_ff;
	logic [5:0] cnt_ff;
	logic [23:0] addr_ff;
	logic [7:0] mode_ff;
	logic cont_ff, dual_ff, sleep_ff, sleep_pend_ff, op_ok_ff;
	logic [2:0] wrap_ff;
	logic [31:0] dp_cnt_ff;
	logic [3:0] oe_n_ff, dout_ff;
	logic [7:0] op_ff;

	wire [7:0] op_byte = {sh_ff[6:0], io_ff[0]};
	wire [3:0] lat_tot = VAR_LAT ? lat_cfg_i : QRS_LAT_RESET;
	wire wrap_on = ~wrap_ff[QRS_WRAP_DIS_BIT-4];
	wire [1:0] wlen = wrap_ff[2:1];
	wire [5:0] wmask = (wlen == 2'h0) ? 6'h07 : (wlen == 2'h1) ? 6'h0f :
		(wlen == 2'h2) ? 6'h1f : 6'h3f;
	wire [23:0] addr_inc = addr_ff + 24'h1;
	wire [23:0] addr_wrap = {addr_ff[23:6],
		(addr_ff[5:0] & ~wmask) | (addr_inc[5:0] & wmask)};
	wire [23:0] addr_nxt = (wrap_on && !dual_ff) ? addr_wrap : addr_inc;
	wire [5:0] addr_clks = dual_ff ? 6'd12 : 6'd6;
	wire [5:0] mode_clks = dual_ff ? 6'd4 : 6'd2;
	wire [1:0] mode_sel = mode_ff[QRS_SKIP_LSB+1:QRS_SKIP_LSB];

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_ff <= ST_OP;
			sh_ff <= 8'h00;
			cnt_ff <= 6'h0;
			addr_ff <= 24'h0;
			mode_ff <= 8'h00;
			cont_ff <= 1'b0;
			dual_ff <= 1'b0;
			sleep_ff <= 1'b0;
			sleep_pend_ff <= 1'b0;
			op_ok_ff <= 1'b0;
			wrap_ff <= QRS_WRAP_RESET;
			dp_cnt_ff <= 32'h0;
			oe_n_ff <= 4'hf;
			dout_ff <= 4'h0;
			op_ff <= 8'h00;
		end else begin
			if (sleep_pend_ff) begin
				dp_cnt_ff <= dp_cnt_ff + 32'h1;
				if (dp_cnt_ff >= 32'(SLEEP_CYC - 1)) begin
					sleep_ff <= 1'b1;
					sleep_pend_ff <= 1'b0;
				end
			end
			if (cs_n_ff) begin
				oe_n_ff <= 4'hf;
				cnt_ff <= 6'h0;
				st_ff <= cont_ff ? ST_ADDR : ST_OP;
				if (cs_rise && op_ok_ff) begin
					if (op_ff == QRS_OP_SLEEP && !sleep_ff) begin
						sleep_pend_ff <= 1'b1;
						dp_cnt_ff <= 32'h0;
					end
					if (op_ff == QRS_OP_WAKE)
						sleep_ff <= 1'b0;
				end
				if (cs_rise)
					op_ok_ff <= 1'b0;
			end else if (sck_rise) begin
				cnt_ff <= cnt_ff + 6'h1;
				op_ok_ff <= 1'b0;
				case (st_ff)
				ST_OP: begin
					sh_ff <= op_byte;
					if (cnt_ff == 6'd7) begin
						cnt_ff <= 6'h0;
						op_ff <= op_byte;
						op_ok_ff <= 1'b1;
						if (sleep_ff)
							st_ff <= ST_IGN;
						else if (op_byte == QRS_OP_QUAD_READ && quad_en_i) begin
							dual_ff <= 1'b0;
							st_ff <= ST_ADDR;
						end else if (op_byte == QRS_OP_DUAL_READ) begin
							dual_ff <= 1'b1;
							st_ff <= ST_ADDR;
						end else if (op_byte == QRS_OP_WRAP_SET && quad_en_i)
							st_ff <= ST_WDUM;
						else
							st_ff <= ST_IGN;
					end
				end
				ST_ADDR: begin
					addr_ff <= dual_ff ? {addr_ff[21:0], io_ff[1:0]} :
						{addr_ff[19:0], io_ff};
					if (cnt_ff == addr_clks - 6'h1) begin
						cnt_ff <= 6'h0;
						st_ff <= ST_MODE;
					end
				end
				ST_MODE: begin
					mode_ff <= dual_ff ? {mode_ff[5:0], io_ff[1:0]} :
						{mode_ff[3:0], io_ff};
					if (cnt_ff == 6'h0 && !dual_ff && io_ff == 4'hf)
						cont_ff <= 1'b0;
					if (cnt_ff == mode_clks - 6'h1) begin
						st_ff <= ({2'h0, lat_tot} > mode_clks) ?
							ST_LAT : ST_DATA;
					end
				end
				ST_LAT: begin
					if (cnt_ff == {2'h0, lat_tot} - 6'h1)
						st_ff <= ST_DATA;
				end
				ST_WDUM: begin
					if (cnt_ff == 6'd7)
						st_ff <= ST_END;
					else if (cnt_ff == 6'd6)
						wrap_ff <= io_ff[2:0];
				end
				ST_END, ST_DATA, ST_IGN: begin
				end
				default: st_ff <= ST_IGN;
				endcase
				if (st_ff == ST_MODE && cnt_ff == mode_clks - 6'h1)
					cont_ff <= (dual_ff ? mode_ff[3:2] : mode_ff[1:0])
						== QRS_SKIP_CODE;
			end else if (sck_fall && st_ff == ST_DATA) begin
				oe_n_ff <= dual_ff ? 4'hc : 4'h0;
				dout_ff <= addr_ff[3:0] ^ {4{cnt_ff[0]}};
				if (cnt_ff[0])
					addr_ff <= addr_nxt;
			end
		end
	end

	assign lnk.d_io_o = dout_ff;
	assign lnk.d_io_oe_n = oe_n_ff;
	assign sleep_o = sleep_ff;
	assign wrap_set_o = wrap_ff;
	assign skip_op_o = cont_ff;
	assign addr_o = addr_ff;
	wire unused_ok = ^{mode_sel, wlen};
endmodule // qrs_dev

// [rtl/qrs_host.sv]
/*
 Host end: issues one command per request over the qrs_if link, making
 the serial clock by dividing ref_clk_i. Assumes the device end of qrs_if.
*/
`timescale 1ns/1ps
module qrs_host
	import qrs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link
	qrs_if.host lnk,
	// Request
	input wire logic req_i,
	input wire logic [7:0] op_i,
	input wire logic skip_op_i,
	input wire logic [5:0] nclk_i,
	input wire logic [31:0] data_i,
	output logic busy_o,
	output logic [3:0] rd_o
);
	import qrs_pkg::*;

	logic busy_ff, cs_n_ff, sck_ff;
	logic [2:0] div_ff;
	logic [5:0] cnt_ff, n_ff;
	logic [7:0] op_ff;
	logic [31:0] dat_ff;
	logic [3:0] oe_n_ff, out_ff, rd_ff, io_s1_ff, io_ff;
	logic skip_ff;
	wire half = (div_ff == 3'(QRS_SCK_DIV/2 - 1));
	wire [5:0] opc = skip_ff ? 6'h0 : 6'd8;

	always_ff @(posedge ref_clk_i) begin
		io_s1_ff <= lnk.io;
		io_ff <= io_s1_ff;
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			busy_ff <= 1'b0;
			cs_n_ff <= 1'b1;
			sck_ff <= 1'b0;
			div_ff <= 3'h0;
			cnt_ff <= 6'h0;
			n_ff <= 6'h0;
			op_ff <= 8'h00;
			dat_ff <= 32'h0;
			oe_n_ff <= 4'hf;
			out_ff <= 4'h0;
			rd_ff <= 4'h0;
			skip_ff <= 1'b0;
		end else if (!busy_ff) begin
			if (req_i) begin
				busy_ff <= 1'b1;
				cs_n_ff <= 1'b0;
				op_ff <= op_i;
				skip_ff <= skip_op_i;
				n_ff <= nclk_i;
				dat_ff <= data_i;
				cnt_ff <= 6'h0;
				div_ff <= 3'h0;
				oe_n_ff <= 4'h0;
				out_ff <= skip_op_i ? data_i[31:28] : {3'h0, op_i[7]};
			end
		end else begin
			div_ff <= half ? 3'h0 : div_ff + 3'h1;
			if (half) begin
				if (cnt_ff == opc + n_ff) begin
					cs_n_ff <= 1'b1;
					busy_ff <= 1'b0;
					oe_n_ff <= 4'hf;
				end else if (!sck_ff) begin
					sck_ff <= 1'b1;
					rd_ff <= io_ff;
				end else begin
					sck_ff <= 1'b0;
					cnt_ff <= cnt_ff + 6'h1;
					if (cnt_ff + 6'h1 < opc) begin
						out_ff <= {3'h0, op_ff[3'(6'd6 - cnt_ff)]};
					end else if (cnt_ff + 6'h1 == opc) begin
						out_ff <= dat_ff[31:28];
					end else begin
						out_ff <= dat_ff[27:24];
						dat_ff <= {dat_ff[27:0], 4'h0};
					end
					if (cnt_ff + 6'h1 == opc + 6'd7)
						oe_n_ff <= 4'hf;
				end
			end
		end
	end

	assign lnk.cs_n = cs_n_ff;
	assign lnk.sck = sck_ff;
	assign lnk.h_io_o = out_ff;
	assign lnk.h_io_oe_n = oe_n_ff;
	assign busy_o = busy_ff;
	assign rd_o = rd_ff;
endmodule // qrs_host

// [tb/qrs_sva.sv]
/*
 Checker for the qrs_if link between the host end and the device end.
 Assumes the bench instantiates it beside the interface, on ref_clk_i.
*/
`timescale 1ns/1ps
module qrs_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] h_io_oe_n,
	input wire logic [3:0] d_io_oe_n
);
////////////////////////////////////////////////////////////////////////////
default clocking dc @(posedge ref_clk_i);
endclocking
default disable iff (!rst_n_i);
a_sck_in_frame: assert property (sck |-> !cs_n)
	else $error("serial clock high outside a frame");
a_sck_high_len: assert property ($rose(sck) |=> sck [*3] ##1 !sck)
	else $error("serial clock high phase not four cycles");
a_sck_low_len: assert property ($fell(sck) && !cs_n |=> !sck [*3])
	else $error("serial clock low phase too short");
a_cs_fall_low: assert property ($fell(cs_n) |-> !sck)
	else $error("select fell with serial clock high");
a_cs_rise_low: assert property ($rose(cs_n) |-> !sck)
	else $error("select rose with serial clock high");
a_cs_min_high: assert property ($rose(cs_n) |=> cs_n)
	else $error("select high for a single cycle");
a_dev_quiet: assert property (cs_n [*4] |-> &d_io_oe_n)
	else $error("device drives lines while deselected");
a_no_contend: assert property ((~h_io_oe_n & ~d_io_oe_n) == 4'h0)
	else $error("host and device drive a line together");
endmodule // qrs_sva

// [tb/quad_io_read_mode_and_sleep_tb.sv]
/*
 Self-checking bench: host end and device end joined by qrs_if.
 Assumes the host makes the link clock and the IO lines have pull-ups.
*/
`timescale 1ns/1ps
module quad_io_read_mode_and_sleep_tb;
import qrs_pkg::*;
typedef struct {logic q; logic [7:0] op; logic sk; logic [5:0] n;
	logic [31:0] d; logic [2:0] w; logic s; logic k;} qrs_row_t;
logic ref_clk_i, rst_n_i, req_i, skip_op_i, quad_en_i, busy_o;
logic sleep_o, skip_op_o;
logic [7:0] op_i;
logic [5:0] nclk_i;
logic [31:0] data_i;
logic [3:0] lat_cfg_i;
logic [2:0] wrap_set_o;
int n_mismatch = 0;
int tests_run = 0;
int cyc = 0;
qrs_row_t rows [10] = '{
	'{1'h1, 8'hff, 1'h0, 6'h00, 32'h0, 3'h1, 1'h0, 1'h0},
	'{1'h1, 8'h77, 1'h0, 6'h08, 32'h60, 3'h6, 1'h0, 1'h0},
	'{1'h1, 8'heb, 1'h0, 6'h10, 32'h0123452f, 3'h6, 1'h0, 1'h1},
	'{1'h1, 8'heb, 1'h1, 6'h10, 32'h10e5, 3'h6, 1'h0, 1'h1},
	'{1'h1, 8'heb, 1'h1, 6'h10, 32'h2010, 3'h6, 1'h0, 1'h0},
	'{1'h1, 8'h77, 1'h0, 6'h08, 32'h10, 3'h1, 1'h0, 1'h0},
	'{1'h0, 8'h77, 1'h0, 6'h08, 32'h60, 3'h1, 1'h0, 1'h0},
	'{1'h1, 8'hb9, 1'h0, 6'h00, 32'h0, 3'h1, 1'h1, 1'h0},
	'{1'h1, 8'h77, 1'h0, 6'h08, 32'h60, 3'h1, 1'h1, 1'h0},
	'{1'h1, 8'hab, 1'h0, 6'h00, 32'h0, 3'h1, 1'h0, 1'h0}
};
////////////////////////////////////////////////////////////////////////////
qrs_if lnk ();
assign lnk.io = (~lnk.h_io_oe_n & lnk.h_io_o) |
	(~lnk.d_io_oe_n & lnk.d_io_o) | (lnk.h_io_oe_n & lnk.d_io_oe_n);
qrs_host i_qrs_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.lnk(lnk.host), .req_i(req_i), .op_i(op_i), .skip_op_i(skip_op_i),
	.nclk_i(nclk_i), .data_i(data_i), .busy_o(busy_o), .rd_o());
qrs_dev #(.SLEEP_CYC(4), .VAR_LAT(1'b0)) i_qrs_dev (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .lnk(lnk.dev), .lat_cfg_i(lat_cfg_i),
	.quad_en_i(quad_en_i), .sleep_o(sleep_o), .wrap_set_o(wrap_set_o),
	.skip_op_o(skip_op_o), .addr_o());
qrs_sva i_qrs_sva (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.cs_n(lnk.cs_n), .sck(lnk.sck), .h_io_oe_n(lnk.h_io_oe_n),
	.d_io_oe_n(lnk.d_io_oe_n));
////////////////////////////////////////////////////////////////////////////
task report_and_stop;
	$display("mismatches %0d of %0d checks", n_mismatch, tests_run);
	if (n_mismatch == 0 && tests_run > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
	tests_run++;
	if (g !== e) begin
		n_mismatch++;
		$display("CHECK FAILED %s exp %h got %h", nm, e, g);
	end
endtask
task chk_state(input logic [2:0] w, input logic s, input logic k);
	chk("wrap_set_o", w, wrap_set_o);
	chk("sleep_o", {2'h0, s}, {2'h0, sleep_o});
	chk("skip_op_o", {2'h0, k}, {2'h0, skip_op_o});
endtask
task send(input logic [7:0] op, input logic sk, input logic [5:0] n,
	input logic [31:0] d);
	int i;
	op_i <= op;
	skip_op_i <= sk;
	nclk_i <= n;
	data_i <= d;
	req_i <= 1'h1;
	@(posedge ref_clk_i);
	req_i <= 1'h0;
	for (i = 0; i < 2000 && (i < 2 || busy_o !== 1'h0); i++)
		@(posedge ref_clk_i);
	repeat (12) @(posedge ref_clk_i);
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
	ref_clk_i = 1'h0;
	forever #2 ref_clk_i = ~ref_clk_i;
end
always @(posedge ref_clk_i) begin
	cyc <= cyc + 1;
	if (cyc == 10000) begin
		n_mismatch++;
		report_and_stop();
	end
end
initial begin
	rst_n_i = 1'h0;
	req_i = 1'h0;
	op_i = 8'h0;
	skip_op_i = 1'h0;
	nclk_i = 6'h0;
	data_i = 32'h0;
	quad_en_i = 1'h1;
	lat_cfg_i = QRS_LAT_RESET;
	repeat (8) @(posedge ref_clk_i);
	rst_n_i <= 1'h1;
	@(posedge ref_clk_i);
	chk_state(3'h1, 1'h0, 1'h0);
	foreach (rows[i]) begin
		quad_en_i <= rows[i].q;
		send(rows[i].op, rows[i].sk, rows[i].n, rows[i].d);
		chk_state(rows[i].w, rows[i].s, rows[i].k);
	end
	send(QRS_OP_SLEEP, 1'h0, 6'h02, 32'h0);
	chk_state(3'h1, 1'h0, 1'h0);
	send(QRS_OP_QUAD_READ, 1'h0, 6'h10, 32'h4020);
	chk_state(3'h1, 1'h0, 1'h1);
	rst_n_i <= 1'h0;
	@(posedge ref_clk_i);
	rst_n_i <= 1'h1;
	@(posedge ref_clk_i);
	chk_state(3'h1, 1'h0, 1'h0);
	send(QRS_OP_MODE_RESET, 1'h0, 6'h00, 32'h0);
	chk_state(3'h1, 1'h0, 1'h0);
	send(QRS_OP_WRAP_SET, 1'h0, 6'h08, 32'h10);
	chk_state(3'h1, 1'h0, 1'h0);
	report_and_stop();
end
endmodule // quad_io_read_mode_and_sleep_tb
